// [rtl/spisd_core.sv]
// Purpose: status flags and data register of a byte wide spi master/slave
// Assumes: mode 0 link (sample rising, shift falling), msb first
// Notes:   registers on classic wishbone, index times four is the byte address
// Overview of operation
// R1 - set done flag when a byte transfer finishes
// R2 - set done flag when a received byte enters the read buffer
// R3 - interrupt while done flag set and both enables on
// R4 - data writes ignored and shifter untouched while done flag set
// R5 - set collision flag on a write collision
// R6 - done, collision, overrun, fault flags clear only by software
// R7 - overrun sets its flag and interrupts if both enables on
// R8 - master with detection enabled uses select pin as fault input
// R9 - select pulled low as fault input sets fault flag at once
// R10 - fault disable bit only matters in master mode
// R11 - disable bit zero: select is fault input regardless of output enable
// R12 - disable bit one: output enable decides select pin behaviour
// R13 - read only buffer bit: 0 empty, 1 full
// R14 - data write loads the transmit shifter
// R15 - data read returns the read buffer, not the shifter
// R16 - master starts one full duplex exchange per accepted write
// R17 - master with output enable and disable bit one drives select low in transfer, high idle
// R18 - write during a transfer counts as a collision
`timescale 1ns/10ps
`include "spisd_regs.svh"
module spisd_core (
   // system
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [9:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // spi link
   input  wire logic        sck_i,
   output logic             sck_o,
   output logic             sck_oe_o,
   input  wire logic        mosi_i,
   output logic             mosi_o,
   output logic             mosi_oe_o,
   input  wire logic        miso_i,
   output logic             miso_o,
   output logic             miso_oe_o,
   input  wire logic        ss_n_i,
   output logic             ss_n_o,
   output logic             ss_n_oe_o,
   // interrupt
   output logic             irq_o
);
   spisd_pkg::spisd_state_t state_reg;
   logic [7:0] shift_reg, rxbuf_reg;
   logic [2:0] bitcnt_reg;
   logic [7:0] div_reg;
   logic       done_reg, write_collision_flag_reg, ovf_reg, mode_fault_flag_reg, fault_detect_disable_reg, txfull_reg;
   logic       master_select_reg, select_output_enable_reg, sie_reg, gie_reg, sampled_reg;
   logic [2:0] sck_sync_reg, mosi_sync_reg, miso_sync_reg, ss_sync_reg;
   logic       sck_prev_reg, ss_prev_reg, slv_busy_reg, slv_phase_reg;

   // three stage samplers; a clock or select change counts when stages two and three agree, data uses stage three
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sck_sync_reg  <= 3'h0;
         mosi_sync_reg <= 3'h0;
         miso_sync_reg <= 3'h0;
         ss_sync_reg   <= 3'h7;
      end else begin
         sck_sync_reg  <= {sck_sync_reg[1:0], sck_i};
         mosi_sync_reg <= {mosi_sync_reg[1:0], mosi_i};
         miso_sync_reg <= {miso_sync_reg[1:0], miso_i};
         ss_sync_reg   <= {ss_sync_reg[1:0], ss_n_i};
      end
   end

   logic sck_s, ss_s, mosi_s, miso_s;
   assign sck_s  = (sck_sync_reg[2] == sck_sync_reg[1]) ? sck_sync_reg[2] : sck_prev_reg;
   assign ss_s   = (ss_sync_reg[2] == ss_sync_reg[1]) ? ss_sync_reg[2] : ss_prev_reg;
   assign mosi_s = mosi_sync_reg[2];
   assign miso_s = miso_sync_reg[2];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sck_prev_reg <= 1'b0;
         ss_prev_reg  <= 1'b1;
      end else begin
         sck_prev_reg <= sck_s;
         ss_prev_reg  <= ss_s;
      end
   end

   logic sck_rise, sck_fall, ss_fall;
   assign sck_rise = sck_s & ~sck_prev_reg;
   assign sck_fall = ~sck_s & sck_prev_reg;
   assign ss_fall  = ~ss_s & ss_prev_reg;

   // bus decode
   logic       bus_req, ack_next, rd_status, wr_data, wr_status, wr_ctrl, wr_irq;
   logic [7:0] idx;
   assign bus_req   = cyc_i & stb_i & ~ack_o;
   assign idx       = adr_i[9:2];
   assign ack_next  = bus_req;
   assign wr_data   = bus_req & we_i & sel_i[0] & (idx == `SPISD_IDX_DATA);
   assign wr_status = bus_req & we_i & sel_i[0] & (idx == `SPISD_IDX_STATUS);
   assign wr_ctrl   = bus_req & we_i & sel_i[0] & (idx == `SPISD_IDX_CTRL);
   assign wr_irq    = bus_req & we_i & sel_i[0] & (idx == `SPISD_IDX_IRQ);
   assign rd_status = bus_req & ~we_i & (idx == `SPISD_IDX_STATUS);

   logic fault_in, master_busy, busy, accept_wr, byte_end, m_last, slv_active;
   assign fault_in    = master_select_reg & ~fault_detect_disable_reg;                      // R8 R10 R11
   assign master_busy = (state_reg != spisd_pkg::SPISD_IDLE);
   assign slv_active  = ~master_select_reg & ~ss_s;
   assign busy        = master_busy | slv_busy_reg;
   // a write lands only when no flag blocks it and no byte is moving
   assign accept_wr   = wr_data & ~done_reg & ~busy & ~mode_fault_flag_reg;      // R4 R14
   assign m_last      = (state_reg == spisd_pkg::SPISD_TRAIL) && (div_reg == 8'h00)
                        && (bitcnt_reg == 3'h7);
   assign byte_end    = m_last | (slv_active & sck_fall & (bitcnt_reg == 3'h7));

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= ack_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (bus_req & ~we_i) begin
         case (idx)
            `SPISD_IDX_DATA:   dat_o <= {24'h000000, rxbuf_reg};            // R15
            `SPISD_IDX_STATUS: dat_o <= {24'h000000, done_reg, write_collision_flag_reg, ovf_reg, mode_fault_flag_reg,
                                         fault_detect_disable_reg, txfull_reg, 2'b00};    // R13
            `SPISD_IDX_CTRL:   dat_o <= {28'h0000000, 2'b00, select_output_enable_reg, master_select_reg};
            `SPISD_IDX_IRQ:    dat_o <= {28'h0000000, gie_reg, sie_reg, 2'b00};
            default:           dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // control bits
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         master_select_reg    <= 1'b0;
         select_output_enable_reg    <= 1'b0;
         sie_reg     <= 1'b0;
         gie_reg     <= 1'b0;
         fault_detect_disable_reg <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            master_select_reg <= dat_i[`SPISD_BIT_MASTER_SELECT];
            select_output_enable_reg <= dat_i[`SPISD_BIT_SELECT_OUTPUT_ENABLE];
         end
         if (wr_irq) begin
            sie_reg <= dat_i[`SPISD_BIT_SIE];
            gie_reg <= dat_i[`SPISD_BIT_GIE];
         end
         if (wr_status) begin
            fault_detect_disable_reg <= dat_i[`SPISD_BIT_FAULT_DETECT_DISABLE];
         end
      end
   end

   // sticky flags: software writes zero to clear, a same-cycle event wins
   logic ovf_evt, write_collision_flag_evt, mode_fault_flag_evt;
   assign write_collision_flag_evt = wr_data & busy;                                   // R5 R18
   assign ovf_evt  = byte_end & done_reg;
   assign mode_fault_flag_evt = fault_in & ss_fall;                               // R9

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_reg <= 1'b0;
         write_collision_flag_reg <= 1'b0;
         ovf_reg  <= 1'b0;
         mode_fault_flag_reg <= 1'b0;
      end else begin
         if (byte_end) begin
            done_reg <= 1'b1;                                          // R1 R2
         end else if (wr_status & ~dat_i[`SPISD_BIT_DONE]) begin
            done_reg <= 1'b0;                                          // R6
         end
         if (write_collision_flag_evt) begin
            write_collision_flag_reg <= 1'b1;                                          // R5
         end else if (wr_status & ~dat_i[`SPISD_BIT_WRITE_COLLISION_FLAG]) begin
            write_collision_flag_reg <= 1'b0;                                          // R6
         end
         if (ovf_evt) begin
            ovf_reg <= 1'b1;                                           // R7
         end else if (wr_status & ~dat_i[`SPISD_BIT_OVF]) begin
            ovf_reg <= 1'b0;                                           // R6
         end
         if (mode_fault_flag_evt) begin
            mode_fault_flag_reg <= 1'b1;                                          // R9
         end else if (wr_status & ~dat_i[`SPISD_BIT_MODE_FAULT_FLAG]) begin
            mode_fault_flag_reg <= 1'b0;                                          // R6
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= sie_reg & gie_reg & (done_reg | ovf_reg | mode_fault_flag_reg); // R3 R7 R9
      end
   end

   // tx buffer holds the written byte until its exchange ends
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         txfull_reg <= 1'b0;
      end else if (accept_wr) begin
         txfull_reg <= 1'b1;                                           // R13
      end else if (byte_end) begin
         txfull_reg <= 1'b0;                                           // R13
      end
   end

   // read buffer is not overwritten while the done flag is set, even after a data read;
   // the last bit lands in the shifter in this same cycle, so merge it here
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rxbuf_reg <= `SPISD_RST_BYTE;
      end else if (byte_end & ~done_reg) begin
         rxbuf_reg <= {shift_reg[6:0], sampled_reg};                   // R2
      end
   end

   // slave bit phase: after a sampled rise the next bit is put out early,
   // since sampler latency would miss a fast far-side clock otherwise
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         slv_phase_reg <= 1'b0;
      end else if (~slv_active) begin
         slv_phase_reg <= 1'b0;
      end else if (sck_rise) begin
         slv_phase_reg <= 1'b1;
      end else if (sck_fall) begin
         slv_phase_reg <= 1'b0;
      end
   end

   // master sequencer and slave shifter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg    <= spisd_pkg::SPISD_IDLE;
         shift_reg    <= `SPISD_RST_BYTE;
         bitcnt_reg   <= 3'h0;
         div_reg      <= 8'h00;
         sampled_reg  <= 1'b0;
         slv_busy_reg <= 1'b0;
      end else begin
         case (state_reg)
            spisd_pkg::SPISD_IDLE: begin
               if (accept_wr & master_select_reg) begin
                  shift_reg  <= dat_i[7:0];                            // R14 R16
                  bitcnt_reg <= 3'h0;
                  div_reg    <= 8'(`SPISD_HALF_CYC - 1);
                  state_reg  <= spisd_pkg::SPISD_LEAD;
               end else if (accept_wr) begin
                  shift_reg    <= dat_i[7:0];                          // R14
                  slv_busy_reg <= 1'b0;
               end else if (slv_active) begin
                  if (sck_rise) begin
                     sampled_reg  <= mosi_s;
                     slv_busy_reg <= 1'b1;
                  end
                  if (sck_fall) begin
                     shift_reg  <= {shift_reg[6:0], sampled_reg};
                     bitcnt_reg <= bitcnt_reg + 3'h1;
                     if (bitcnt_reg == 3'h7) begin
                        slv_busy_reg <= 1'b0;
                     end
                  end
               end else begin
                  bitcnt_reg   <= 3'h0;
                  slv_busy_reg <= 1'b0;
               end
            end
            spisd_pkg::SPISD_LEAD: begin
               if (mode_fault_flag_reg) begin
                  state_reg <= spisd_pkg::SPISD_IDLE;                  // abort on fault
               end else if (div_reg == 8'h00) begin
                  sampled_reg <= miso_s;
                  div_reg     <= 8'(`SPISD_HALF_CYC - 1);
                  state_reg   <= spisd_pkg::SPISD_TRAIL;
               end else begin
                  div_reg <= div_reg - 8'h01;
               end
            end
            spisd_pkg::SPISD_TRAIL: begin
               if (div_reg == 8'h00) begin
                  shift_reg  <= {shift_reg[6:0], sampled_reg};         // R16
                  bitcnt_reg <= bitcnt_reg + 3'h1;
                  div_reg    <= 8'(`SPISD_HALF_CYC - 1);
                  state_reg  <= (bitcnt_reg == 3'h7) ? spisd_pkg::SPISD_IDLE
                                                     : spisd_pkg::SPISD_LEAD;
               end else begin
                  div_reg <= div_reg - 8'h01;
               end
            end
            default: state_reg <= spisd_pkg::SPISD_IDLE;
         endcase
      end
   end

   // pin drivers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sck_o     <= 1'b0;
         sck_oe_o  <= 1'b0;
         mosi_o    <= 1'b0;
         mosi_oe_o <= 1'b0;
         miso_o    <= 1'b0;
         miso_oe_o <= 1'b0;
         ss_n_o    <= 1'b1;
         ss_n_oe_o <= 1'b0;
      end else begin
         sck_o     <= (state_reg == spisd_pkg::SPISD_TRAIL);
         sck_oe_o  <= master_select_reg;
         mosi_o    <= shift_reg[7];
         mosi_oe_o <= master_select_reg;
         miso_o    <= slv_phase_reg ? shift_reg[6] : shift_reg[7];
         miso_oe_o <= slv_active;
         ss_n_o    <= ~master_busy;                                    // R17
         ss_n_oe_o <= master_select_reg & fault_detect_disable_reg & select_output_enable_reg;               // R12 R17
      end
   end
endmodule // spisd_core

// [inc/spisd_regs.svh]
// Purpose: register offsets, field positions, reset values and timing counts of the spi port
// Assumes: wishbone byte addresses, one register per 32-bit word
// Notes:   printed data offset is not a multiple of four, so offsets are indexes
`ifndef SPISD_REGS_SVH
`define SPISD_REGS_SVH
`define SPISD_IDX_DATA      8'hF5
`define SPISD_IDX_STATUS    8'hF4
`define SPISD_IDX_CTRL      8'hF3
`define SPISD_IDX_IRQ       8'hF2
`define SPISD_BIT_DONE      7
`define SPISD_BIT_WRITE_COLLISION_FLAG      6
`define SPISD_BIT_OVF       5
`define SPISD_BIT_MODE_FAULT_FLAG      4
`define SPISD_BIT_FAULT_DETECT_DISABLE   3
`define SPISD_BIT_TXFULL    2
`define SPISD_BIT_MASTER_SELECT      0
`define SPISD_BIT_SELECT_OUTPUT_ENABLE      1
`define SPISD_BIT_SIE       2
`define SPISD_BIT_GIE       3
`define SPISD_RST_BYTE      8'h00
`define SPISD_HALF_NS       64
`define SPISD_CLK_NS        4
`define SPISD_HALF_CYC      (`SPISD_HALF_NS / `SPISD_CLK_NS)
`endif

// [inc/spisd_pkg.sv]
// Purpose: types of the spi status and data port
// Assumes: nothing
// Notes:   constants live in spisd_regs.svh
package spisd_pkg;
   typedef enum logic [1:0] {SPISD_IDLE, SPISD_LEAD, SPISD_TRAIL} spisd_state_t;
endpackage

// [tb/spisd_checker.sv]
// Purpose: port assertions of the spi port
// Assumes: enables and modes shadowed from bus writes on lane 0
// Notes:   frame checks only while the block drives select
`timescale 1ns/10ps
`include "spisd_regs.svh"
module spisd_checker (
   // bus
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [9:0]  adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   // link and interrupt
   input wire logic        sck_o,
   input wire logic        ss_n_i,
   input wire logic        ss_n_o,
   input wire logic        ss_n_oe_o,
   input wire logic        irq_o
);
   logic       en_reg, mst_reg, dis_reg, rd_reg, sck_reg;
   logic [3:0] cnt_reg;
   wire        take = cyc_i && stb_i && !ack_o;
   wire        wr   = take && we_i && sel_i[0];
   wire [7:0]  ix   = adr_i[9:2];
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {en_reg, mst_reg, dis_reg, rd_reg} <= 4'h0;
      end else if (take) begin
         rd_reg <= !we_i && ix == `SPISD_IDX_STATUS;
         if (wr && ix == `SPISD_IDX_IRQ) en_reg <= dat_i[2] & dat_i[3];
         if (wr && ix == `SPISD_IDX_CTRL) mst_reg <= dat_i[0];
         if (wr && ix == `SPISD_IDX_STATUS) dis_reg <= dat_i[3];
      end
   end
   // rising link clock edges within one select period
   always_ff @(posedge clk_i) begin
      sck_reg <= sck_o;
      if (rst_i || ss_n_o) cnt_reg <= 4'h0;
      else if (sck_o && !sck_reg) cnt_reg <= cnt_reg + 4'h1;
   end
   sequence s_take;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence s_answer;
      ack_o ##1 !ack_o;
   endsequence
   AST_ACK: assert property (s_take |=> s_answer)
      else $error("bus answer not one cycle");
   AST_MASK: assert property (!en_reg && !$past(en_reg) |-> !irq_o)
      else $error("irq while disabled");
   AST_IRQ_DONE: assert property (ack_o && rd_reg && dat_o[7] && $past(en_reg, 2) |-> irq_o)
      else $error("done flag without irq");
   AST_STICKY: assert property (irq_o && !wr && !$past(wr) && !$past(wr, 2) |=> irq_o)
      else $error("irq dropped without software");
   AST_FAULT: assert property (
      $fell(ss_n_i) && mst_reg && !dis_reg && en_reg |-> ##[1:8] irq_o)
      else $error("fault without irq");
   AST_FRAME: assert property ($rose(ss_n_o) && ss_n_oe_o |-> cnt_reg == 4'h8)
      else $error("frame not eight clocks");
   AST_IDLE_SCK: assert property (ss_n_oe_o && ss_n_o && $past(ss_n_o, 2) |-> !sck_o)
      else $error("link clock moves while idle");
   AST_TX_BUFFER_FULL: assert property (
      ack_o && rd_reg && ss_n_oe_o && !ss_n_o && !$past(ss_n_o) |-> dat_o[2])
      else $error("buffer empty during frame");
endmodule // spisd_checker
bind spisd_core spisd_checker spisd_checker_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
   .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .sck_o, .ss_n_i, .ss_n_o, .ss_n_oe_o, .irq_o);

// [tb/spisd_partner.sv]
// Purpose: far side spi device, slave to the block's master, master to its slave
// Assumes: mode 0, msb first, select pulled up
// Notes:   link clock stands still between frames
`timescale 1ns/10ps
module spisd_partner (
   // wire levels
   input  wire logic       sck_w_i,
   input  wire logic       ss_n_w_i,
   input  wire logic       mosi_w_i,
   input  wire logic       miso_w_i,
   input  wire logic [7:0] reply_i,
   // drives
   output logic            sck_o,
   output logic            ss_n_o,
   output logic            mosi_o,
   output logic            miso_o,
   output logic [7:0]      rx_o
);
   logic [7:0] sh_reg  = 8'h00;
   logic       drv_reg = 1'b0;
   initial {sck_o, ss_n_o, mosi_o, rx_o} = {3'b010, 8'h00};
   always @(negedge ss_n_w_i) sh_reg = reply_i;
   always @(negedge sck_w_i) if (!ss_n_w_i) sh_reg = {sh_reg[6:0], 1'b0};
   always @(posedge sck_w_i) if (!ss_n_w_i) rx_o = {rx_o[6:0], drv_reg ? miso_w_i : mosi_w_i};
   // deselected, the line shows the inverse of the top bit of its shifter
   assign miso_o = ss_n_w_i ? ~sh_reg[7] : sh_reg[7];
   task automatic frame(input logic [7:0] b);
      #1 drv_reg = 1'b1;
      ss_n_o = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         mosi_o = b[i];
         #16 sck_o = 1'b1;
         #16 sck_o = 1'b0;
      end
      #16 ss_n_o = 1'b1;
      mosi_o = ~mosi_o;
      drv_reg = 1'b0;
   endtask
endmodule // spisd_partner

// [tb/spi_status_and_data_port_test.sv]
// Purpose: self checking bench of the spi status and data port
// Assumes: far side modelled by spisd_partner
// Notes:   registers reached by classic wishbone single cycles
`timescale 1ns/10ps
`include "spisd_regs.svh"
module spi_status_and_data_port_test;
   localparam logic [7:0] st = `SPISD_IDX_STATUS;
   localparam logic [7:0] dt = `SPISD_IDX_DATA;
   localparam logic [7:0] ct = `SPISD_IDX_CTRL;
   localparam logic [7:0] ie = `SPISD_IDX_IRQ;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [9:0]  adr_i = 10'h000;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o;
   logic        ack_o, sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o, irq_o;
   logic        ss_n_o, ss_n_oe_o, p_sck, p_ss_n, p_mosi, p_miso;
   logic [7:0]  p_rx, q, reply = 8'hA5;
   int          mismatches = 0, checks = 0;
   wire         sck_w  = sck_oe_o ? sck_o : p_sck;
   wire         mosi_w = mosi_oe_o ? mosi_o : p_mosi;
   wire         miso_w = miso_oe_o ? miso_o : p_miso;
   wire         ss_w   = ss_n_oe_o ? ss_n_o : p_ss_n;
   always #2 clk_i = ~clk_i;
   spisd_core spisd_core_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
      .dat_o, .ack_o, .sck_i(sck_w), .sck_o, .sck_oe_o, .mosi_i(mosi_w), .mosi_o, .mosi_oe_o,
      .miso_i(miso_w), .miso_o, .miso_oe_o, .ss_n_i(ss_w), .ss_n_o, .ss_n_oe_o, .irq_o);
   spisd_partner spisd_partner_inst (.sck_w_i(sck_w), .ss_n_w_i(ss_w), .mosi_w_i(mosi_w),
      .miso_w_i(miso_w), .reply_i(reply), .sck_o(p_sck), .ss_n_o(p_ss_n), .mosi_o(p_mosi),
      .miso_o(p_miso), .rx_o(p_rx));
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
         mismatches++;
      end
   endtask
   task automatic complete_run();
      if (mismatches == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [7:0] ix, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, sel_i} <= {2'b11, w, 4'hF};
      adr_i <= {ix, 2'b00};
      dat_i <= {24'h000000, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      q = dat_o[7:0];
      {cyc_i, stb_i} <= 2'b00;
      if (n >= 20) begin
         chk("bus ack", 8'h00, 8'h01);
         complete_run();
      end
   endtask
   task automatic rd(input string nm, input logic [7:0] ix, input logic [7:0] exp);
      wb(1'b0, ix, 8'h00);
      chk(nm, q, exp);
   endtask
   // bounded poll of the status register for any bit of the mask
   task automatic poll(input logic [7:0] m);
      q = 8'h00;
      for (int n = 0; n < 150 && (q & m) == 8'h00; n++) wb(1'b0, st, 8'h00);
      if ((q & m) == 8'h00) begin
         chk("status poll", 8'h00, m);
         complete_run();
      end
   endtask
   task automatic irq(input logic e);
      repeat (3) @(posedge clk_i);
      chk("irq", {7'h00, irq_o}, {7'h00, e});
   endtask
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rd("data", dt, 8'h00);
      rd("status", st, 8'h00);
      wb(1'b1, 8'h10, 8'hFF);
      rd("unmapped", 8'h10, 8'h00);
      wb(1'b1, ie, 8'h0C);
      wb(1'b1, ct, 8'h03);
      wb(1'b1, st, 8'h08);
      wb(1'b1, dt, 8'h3C);
      rd("status", st, 8'h0C);
      wb(1'b1, dt, 8'h55);
      poll(8'h80);
      rd("status", st, 8'hC8);
      irq(1'b1);
      chk("far rx", p_rx, 8'h3C);
      rd("data", dt, 8'hA5);
      wb(1'b1, dt, 8'h11);
      repeat (300) @(posedge clk_i);
      chk("far rx", p_rx, 8'h3C);
      rd("status", st, 8'hC8);
      wb(1'b1, ct, 8'h00);
      wb(1'b1, st, 8'h00);
      irq(1'b0);
      wb(1'b1, dt, 8'h96);
      spisd_partner_inst.frame(8'h5A);
      poll(8'h80);
      chk("far rx", p_rx, 8'h96);
      spisd_partner_inst.frame(8'hC3);
      poll(8'h20);
      rd("status", st, 8'hA0);
      rd("data", dt, 8'h5A);
      wb(1'b1, ie, 8'h04);
      irq(1'b0);
      wb(1'b1, ie, 8'h0C);
      irq(1'b1);
      wb(1'b1, st, 8'h00);
      wb(1'b1, ct, 8'h03);
      chk("select oe", {7'h00, ss_n_oe_o}, 8'h00);
      spisd_partner_inst.frame(8'h00);
      poll(8'h10);
      irq(1'b1);
      wb(1'b1, st, 8'h08);
      repeat (2) @(posedge clk_i);
      chk("select oe", {7'h00, ss_n_oe_o}, 8'h01);
      chk("select idle", {7'h00, ss_w}, 8'h01);
      rd("status", st, 8'h08);
      complete_run();
   end
endmodule // spi_status_and_data_port_test
